// ### core/data_space_pkg.sv
package data_space_pkg;

	// ==========================================================
	// address space layout
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned ADDR_TOP = 15;
	localparam int unsigned NEAR_W = 13;
	localparam logic [15:0] CTRL_LAST = 16'h0fff;
	localparam logic [15:0] NEAR_LAST = 16'h1fff;
	localparam logic [15:0] RAM_BASE = 16'h1000;
	localparam int unsigned RAM_BYTES_DEF = 12288;
	localparam logic [16:0] SPACE_HALF = 17'h08000;

	// ==========================================================
	// byte lanes and pointer steps
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	localparam logic [1:0] LANE_NONE = 2'h0;
	localparam logic [1:0] LANE_LO = 2'h1;
	localparam logic [1:0] LANE_HI = 2'h2;
	localparam logic [1:0] LANE_BOTH = 2'h3;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONES = 8'hff;

	// ==========================================================
	// enumerations
	typedef enum logic [1:0] {
		MODE_NEAR = 2'h0,
		MODE_DIRECT = 2'h1,
		MODE_INDIRECT = 2'h2
	} addr_mode_type;

	typedef enum logic [1:0] {
		REGION_CTRL = 2'h0,
		REGION_RAM = 2'h1,
		REGION_NONE = 2'h2,
		REGION_WINDOW = 2'h3
	} region_type;

	typedef enum logic [2:0] {
		WOP_NONE = 3'h0,
		WOP_WORD = 3'h1,
		WOP_BYTE = 3'h2,
		WOP_SIGN = 3'h3,
		WOP_WIDEN = 3'h4
	} wreg_op_type;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic valid;
		logic is_byte;
		addr_mode_type mode;
		logic [NEAR_W-1:0] near_field;
		logic [ADDR_W-1:0] direct_addr;
		logic [ADDR_W-1:0] pointer;
		logic post_inc;
	} access_req_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [1:0] strobe;
		logic [15:0] data;
	} periph_write_type;

endpackage

// ### core/address_generator.sv
`timescale 1ns/1ps
`default_nettype none

module address_generator #(
	parameter int unsigned RAM_BYTES = data_space_pkg::RAM_BYTES_DEF
) (
	// request
	input wire data_space_pkg::access_req_type req_in,
	// decoded address
	output logic [15:0] ea_out,
	output logic [15:0] ptr_next_out,
	output logic misaligned_out,
	output data_space_pkg::region_type region_out
);
	import data_space_pkg::*;

	localparam logic [16:0] RAM_END = 17'(RAM_BASE) + 17'(RAM_BYTES);

	// ==========================================================
	// effective address, pointer update and region
	always_comb begin
		case (req_in.mode)
			MODE_NEAR: ea_out = 16'(req_in.near_field); // R15 R1
			MODE_DIRECT: ea_out = req_in.direct_addr; // R16
			MODE_INDIRECT: ea_out = req_in.pointer; // R16
			default: ea_out = req_in.pointer;
		endcase
		// byte steps by one, word by two
		if (req_in.mode == MODE_INDIRECT && req_in.post_inc) begin
			ptr_next_out = req_in.pointer + (req_in.is_byte ? STEP_BYTE : STEP_WORD); // R5
		end else begin
			ptr_next_out = req_in.pointer;
		end
		misaligned_out = req_in.valid && !req_in.is_byte && ea_out[0]; // R8
		if (ea_out[ADDR_TOP]) begin
			region_out = REGION_WINDOW; // R2
		end else if (ea_out <= CTRL_LAST) begin
			region_out = REGION_CTRL; // R13
		end else if (ea_out >= RAM_BASE && {1'b0, ea_out} < RAM_END) begin
			region_out = REGION_RAM; // R3
		end else begin
			region_out = REGION_NONE; // R3
		end
	end

endmodule

`default_nettype wire

// ### core/data_word_store.sv
`timescale 1ns/1ps
`default_nettype none

module data_word_store #(
	parameter int unsigned WORDS = data_space_pkg::RAM_BYTES_DEF / 2
) (
	// clock
	input wire logic sys_clk_in,
	// read port
	input wire logic [$clog2(WORDS)-1:0] rd_idx_in,
	output logic [15:0] rd_word_out,
	// write port
	input wire logic [$clog2(WORDS)-1:0] wr_idx_in,
	input wire logic [1:0] wr_strobe_in,
	input wire logic [15:0] wr_word_in
);
	import data_space_pkg::*;

	typedef struct packed {
		logic [WORDS-1:0][1:0][7:0] mem;
	} store_state_type;

	store_state_type state_reg;
	store_state_type state_next;

	if (WORDS < 2) begin : g_chk
		$error("word store needs at least two words");
	end

	// ==========================================================
	// shared word decode, one write line per byte lane
	always_comb begin
		state_next = state_reg;
		for (int l = 0; l < 2; l++) begin
			if (wr_strobe_in[l]) begin
				state_next.mem[wr_idx_in][l] = wr_word_in[l*8 +: 8]; // R7
			end
		end
	end

	// storage holds no control state, so it carries no reset
	always_ff @(posedge sys_clk_in) begin
		state_reg <= state_next;
	end

	assign rd_word_out = state_reg.mem[rd_idx_in];

endmodule

`default_nettype wire

// ### core/data_space_access_decode.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [R1] every effective address is 16 bits wide and names one byte
// [R2] top address bit clear selects implemented memory; set selects the program window
// [R3] up to 12 Kbytes implemented; anything beyond reads as zero
// [R4] words hold the low byte at even address, high byte at odd
// [R5] indirect post-increment steps the pointer by one for bytes, two for words
// [R6] byte read fetches the word, selects by address bit 0, returns on low lane
// [R7] shared word decode with a write strobe per byte lane
// [R8] word accesses at odd addresses raise the address error trap
// [R9] misaligned read completes; misaligned write is suppressed; trap follows
// [R10] byte load into a working register keeps its high byte
// [R11] sign extend widens a signed 8-bit value to 16 bits
// [R12] unsigned widen clears the high byte of a working register
// [R13] control registers occupy 0x0000 to 0x0fff
// [R14] unused control register addresses read as zero
// [R15] 13-bit direct field reaches 0x0000 to 0x1fff
// [R16] 16-bit direct or pointer addressing reaches the whole space
// [R17] read and write addresses come from two independent generators
// [R18] address error is a registered one-cycle pulse aligned with the access
module data_space_access_decode #(
	parameter int unsigned RAM_BYTES = data_space_pkg::RAM_BYTES_DEF
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	// read access
	input wire data_space_pkg::access_req_type rd_req_in,
	output logic [15:0] rd_data_out,
	output logic rd_done_out,
	output logic [15:0] rd_ptr_next_out,
	// write access
	input wire data_space_pkg::access_req_type wr_req_in,
	input wire logic [15:0] wr_data_in,
	output logic wr_done_out,
	output logic [15:0] wr_ptr_next_out,
	// address error trap
	output logic addr_err_out,
	output logic addr_err_write_out,
	// control register port
	output logic periph_rd_en_out,
	output logic [15:0] periph_rd_addr_out,
	input wire logic [15:0] periph_rdata_in,
	input wire logic periph_hit_in,
	output data_space_pkg::periph_write_type periph_wr_out,
	// working register lane unit
	input wire data_space_pkg::wreg_op_type wreg_op_in,
	input wire logic [15:0] wreg_old_in,
	input wire logic [15:0] wreg_load_in,
	output logic [15:0] wreg_result_out
);
	import data_space_pkg::*;

	localparam int unsigned WORDS = RAM_BYTES / 2;
	localparam int unsigned IDX_W = $clog2(WORDS);

	// ==========================================================
	// parameter checks
	if (RAM_BYTES < 4 || RAM_BYTES % 2 != 0) begin : g_chk_even
		$error("RAM_BYTES must be even and at least four");
	end
	if (17'(RAM_BASE) + 17'(RAM_BYTES) > SPACE_HALF) begin : g_chk_fit
		$error("RAM_BYTES does not fit below the program window");
	end

	// ==========================================================
	// state
	typedef struct packed {
		logic [15:0] rd_data;
		logic rd_done;
		logic [15:0] rd_ptr_next;
		logic wr_done;
		logic [15:0] wr_ptr_next;
		logic addr_err;
		logic addr_err_write;
		periph_write_type periph_wr;
		logic [15:0] wreg_result;
	} top_state_type;

	top_state_type state_reg;
	top_state_type state_next;

	// ==========================================================
	// independent read and write address generators
	logic [15:0] rd_ea; // R1
	logic [15:0] rd_ptr_next;
	logic rd_mis;
	region_type rd_region;
	logic [15:0] wr_ea;
	logic [15:0] wr_ptr_next;
	logic wr_mis;
	region_type wr_region;

	address_generator #(.RAM_BYTES(RAM_BYTES)) u_rd_gen ( // R17
		.req_in(rd_req_in),
		.ea_out(rd_ea),
		.ptr_next_out(rd_ptr_next),
		.misaligned_out(rd_mis),
		.region_out(rd_region)
	);

	address_generator #(.RAM_BYTES(RAM_BYTES)) u_wr_gen ( // R17
		.req_in(wr_req_in),
		.ea_out(wr_ea),
		.ptr_next_out(wr_ptr_next),
		.misaligned_out(wr_mis),
		.region_out(wr_region)
	);

	// ==========================================================
	// word store
	logic [15:0] rd_off;
	logic [15:0] wr_off;
	logic [IDX_W-1:0] rd_idx;
	logic [IDX_W-1:0] wr_idx;
	logic [15:0] ram_word;
	logic [1:0] wr_lanes;
	logic [1:0] ram_strobe;
	logic [15:0] wr_word;

	// byte address bit 0 is dropped: both lanes share one word decode
	assign rd_off = rd_ea - RAM_BASE;
	assign wr_off = wr_ea - RAM_BASE;
	assign rd_idx = rd_off[IDX_W:1]; // R4
	assign wr_idx = wr_off[IDX_W:1]; // R4

	always_comb begin
		if (!wr_req_in.is_byte) begin
			wr_lanes = LANE_BOTH;
		end else if (wr_ea[0]) begin
			wr_lanes = LANE_HI; // R4
		end else begin
			wr_lanes = LANE_LO; // R4
		end
	end

	// a byte write presents its byte on both lanes; the strobe picks one
	assign wr_word = wr_req_in.is_byte ? {2{wr_data_in[7:0]}} : wr_data_in; // R7
	// misaligned word writes never reach the array
	assign ram_strobe = (wr_req_in.valid && !wr_mis && wr_region == REGION_RAM) ? wr_lanes : LANE_NONE; // R9

	data_word_store #(.WORDS(WORDS)) u_store (
		.sys_clk_in(sys_clk_in),
		.rd_idx_in(rd_idx),
		.rd_word_out(ram_word),
		.wr_idx_in(wr_idx),
		.wr_strobe_in(ram_strobe),
		.wr_word_in(wr_word)
	);

	// ==========================================================
	// control register read side, always word aligned
	assign periph_rd_en_out = rd_req_in.valid && rd_region == REGION_CTRL; // R13
	assign periph_rd_addr_out = {rd_ea[15:1], 1'b0};

	// ==========================================================
	// next state
	logic [15:0] rd_word;
	logic [15:0] rd_value;

	always_comb begin
		case (rd_region)
			REGION_RAM: rd_word = ram_word;
			REGION_CTRL: rd_word = periph_hit_in ? periph_rdata_in : 16'h0000; // R14
			REGION_WINDOW: rd_word = 16'h0000; // R2
			default: rd_word = 16'h0000; // R3
		endcase
		if (rd_req_in.is_byte) begin
			rd_value = {BYTE_ZERO, rd_ea[0] ? rd_word[15:8] : rd_word[7:0]}; // R6
		end else begin
			rd_value = rd_word;
		end
	end

	always_comb begin
		state_next = state_reg;
		// read completes even when misaligned
		state_next.rd_done = rd_req_in.valid; // R9
		if (rd_req_in.valid) begin
			state_next.rd_data = rd_value; // R6
			state_next.rd_ptr_next = rd_ptr_next; // R5
		end
		state_next.wr_done = wr_req_in.valid; // R9
		if (wr_req_in.valid) begin
			state_next.wr_ptr_next = wr_ptr_next; // R5
		end
		// one pulse per offending cycle, in step with the read answer
		state_next.addr_err = rd_mis || wr_mis; // R18
		state_next.addr_err_write = wr_mis; // R8
		// control register writes go out one cycle after the request
		state_next.periph_wr.addr = {wr_ea[15:1], 1'b0};
		state_next.periph_wr.data = wr_word;
		if (wr_req_in.valid && !wr_mis && wr_region == REGION_CTRL) begin
			state_next.periph_wr.strobe = wr_lanes; // R7
		end else begin
			state_next.periph_wr.strobe = LANE_NONE; // R9
		end
		case (wreg_op_in)
			WOP_WORD: state_next.wreg_result = wreg_load_in;
			WOP_BYTE: state_next.wreg_result = {wreg_old_in[15:8], wreg_load_in[7:0]}; // R10
			WOP_SIGN: state_next.wreg_result = {wreg_old_in[7] ? BYTE_ONES : BYTE_ZERO, wreg_old_in[7:0]}; // R11
			WOP_WIDEN: state_next.wreg_result = {BYTE_ZERO, wreg_old_in[7:0]}; // R12
			default: state_next.wreg_result = wreg_old_in;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// outputs
	assign rd_data_out = state_reg.rd_data;
	assign rd_done_out = state_reg.rd_done;
	assign rd_ptr_next_out = state_reg.rd_ptr_next;
	assign wr_done_out = state_reg.wr_done;
	assign wr_ptr_next_out = state_reg.wr_ptr_next;
	assign addr_err_out = state_reg.addr_err;
	assign addr_err_write_out = state_reg.addr_err_write;
	assign periph_wr_out = state_reg.periph_wr;
	assign wreg_result_out = state_reg.wreg_result;

	// ==========================================================
	// assertions
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!nrst_in);

	AST_ERR_ON_MISALIGN: assert property ( // R8
		(rd_req_in.valid && !rd_req_in.is_byte && rd_ea[0]) |=> addr_err_out
	) else $error("misaligned word read raised no trap");

	AST_ERR_HAS_CAUSE: assert property ( // R18
		addr_err_out |-> $past(rd_mis || wr_mis)
	) else $error("address error without a misaligned access");

	AST_ERR_WRITE_FLAG: assert property ( // R9
		(wr_req_in.valid && !wr_req_in.is_byte && wr_ea[0]) |=> (addr_err_out && addr_err_write_out)
	) else $error("misaligned write not reported as write trap");

	AST_WRITE_SUPPRESSED: assert property ( // R9
		(wr_req_in.valid && !wr_req_in.is_byte && wr_ea[0]) |-> (ram_strobe == LANE_NONE)
		##1 (periph_wr_out.strobe == LANE_NONE)
	) else $error("misaligned write reached memory");

	AST_READ_COMPLETES: assert property ( // R9
		rd_req_in.valid |=> rd_done_out
	) else $error("read did not complete");

	AST_WINDOW_ZERO: assert property ( // R2
		(rd_req_in.valid && rd_ea[ADDR_TOP]) |=> (rd_data_out == 16'h0000)
	) else $error("upper half read not zero");

	AST_BEYOND_ZERO: assert property ( // R3
		(rd_req_in.valid && rd_region == REGION_NONE) |=> (rd_data_out == 16'h0000)
	) else $error("unimplemented read not zero");

	AST_CTRL_UNUSED_ZERO: assert property ( // R14
		(rd_req_in.valid && rd_region == REGION_CTRL && !periph_hit_in) |=> (rd_data_out == 16'h0000)
	) else $error("unused control register read not zero");

	AST_BYTE_LOW_LANE: assert property ( // R6
		(rd_req_in.valid && rd_req_in.is_byte) |=> (rd_data_out[15:8] == BYTE_ZERO)
	) else $error("byte read left data on high lane");

	AST_PTR_STEP: assert property ( // R5
		(rd_req_in.valid && rd_req_in.mode == MODE_INDIRECT && rd_req_in.post_inc)
		|=> (rd_ptr_next_out == $past(rd_req_in.pointer) + ($past(rd_req_in.is_byte) ? STEP_BYTE : STEP_WORD))
	) else $error("pointer post-increment step wrong");

	AST_NEAR_RANGE: assert property ( // R15
		(rd_req_in.mode == MODE_NEAR) |-> (rd_ea <= NEAR_LAST)
	) else $error("near address outside near space");

	AST_BYTE_LANE_STROBE: assert property ( // R7
		(wr_req_in.valid && wr_req_in.is_byte && wr_region == REGION_RAM) |-> (ram_strobe == (wr_ea[0] ? LANE_HI : LANE_LO))
	) else $error("byte write strobe on wrong lane");

	AST_BYTE_LOAD_KEEP: assert property ( // R10
		(wreg_op_in == WOP_BYTE) |=> (wreg_result_out[15:8] == $past(wreg_old_in[15:8]))
	) else $error("byte load changed high byte");

	AST_SIGN_EXTEND: assert property ( // R11
		(wreg_op_in == WOP_SIGN)
		|=> (wreg_result_out == {{8{$past(wreg_old_in[7])}}, $past(wreg_old_in[7:0])})
	) else $error("sign extend result wrong");

	AST_WIDEN: assert property ( // R12
		(wreg_op_in == WOP_WIDEN) |=> (wreg_result_out == {BYTE_ZERO, $past(wreg_old_in[7:0])})
	) else $error("unsigned widen result wrong");

	AST_WRITE_DONE: assert property ( // R9
		wr_req_in.valid |=> wr_done_out
	) else $error("write not acknowledged");

	AST_CTRL_READ_ENABLE: assert property ( // R13
		periph_rd_en_out |-> (rd_req_in.valid && rd_ea <= CTRL_LAST)
	) else $error("control read outside control region");

	AST_CTRL_ADDR_EVEN: assert property ( // R7
		periph_rd_addr_out[0] == 1'b0
	) else $error("control read address not word aligned");

	AST_WR_PTR_STEP: assert property ( // R5
		(wr_req_in.valid && wr_req_in.mode == MODE_INDIRECT && wr_req_in.post_inc)
		|=> (wr_ptr_next_out == $past(wr_req_in.pointer) + ($past(wr_req_in.is_byte) ? STEP_BYTE : STEP_WORD))
	) else $error("write pointer post-increment step wrong");

	AST_ERR_WRITE_SUBSET: assert property ( // R8
		addr_err_write_out |-> addr_err_out
	) else $error("write trap flag without address error");

	AST_RAM_STROBE_REGION: assert property ( // R3
		(ram_strobe != LANE_NONE) |-> (wr_req_in.valid && wr_region == REGION_RAM)
	) else $error("memory written outside implemented area");

	COV_MISALIGNED_WRITE: cover property (
		wr_req_in.valid && wr_mis ##1 addr_err_write_out
	);

	COV_ODD_BYTE_READ: cover property (
		rd_req_in.valid && rd_req_in.is_byte && rd_ea[0] && rd_region == REGION_RAM ##1 rd_done_out
	);

	COV_WRITE_THEN_READ: cover property (
		wr_req_in.valid && wr_region == REGION_RAM ##1 rd_req_in.valid && rd_region == REGION_RAM
	);

	COV_CTRL_WRITE: cover property (
		wr_req_in.valid && wr_region == REGION_CTRL ##1 periph_wr_out.strobe != LANE_NONE
	);

endmodule

`default_nettype wire

// ### test/periph_reg_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// control register file standing in for the peripherals
module periph_reg_model (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	// read side
	input wire logic [15:0] rd_addr_in,
	output logic [15:0] rdata_out,
	output logic hit_out,
	// write side
	input wire data_space_pkg::periph_write_type wr_in
);
	import data_space_pkg::*;

	logic [15:0] regs_reg [8];

	// only eight words are used, the rest of the region is a gap
	assign hit_out = rd_addr_in < 16'h0010;
	// a gap answers junk, so a design that forgets to clear it is caught
	assign rdata_out = hit_out ? regs_reg[rd_addr_in[3:1]] : ~rd_addr_in;

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			for (int i = 0; i < 8; i++) begin
				regs_reg[i] <= 16'h0000;
			end
		end else if (wr_in.addr < 16'h0010) begin
			if (wr_in.strobe[0]) regs_reg[wr_in.addr[3:1]][7:0] <= wr_in.data[7:0];
			if (wr_in.strobe[1]) regs_reg[wr_in.addr[3:1]][15:8] <= wr_in.data[15:8];
		end
	end
endmodule

`default_nettype wire

// ### test/tb_data_space_access_decode.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; $display("BAD %0t %h vs %h", $time, g, e); end end

module tb_data_space_access_decode;
	import data_space_pkg::*;

	// ==========================================================
	// signals
	localparam int RAMB = 64;
	typedef struct packed {
		int stamp;
		logic rv;
		logic [15:0] rdat;
		logic [15:0] rptr;
		logic wv;
		logic [15:0] wptr;
		logic err;
		logic errw;
		logic [15:0] wres;
	} note_type;
	logic sys_clk_in, nrst_in, rd_done, wr_done, aerr, aerr_w, prd_en, phit;
	access_req_type rd_req, wr_req, idle;
	wreg_op_type wop;
	logic [15:0] wr_data, wold, wload, rd_data, rd_ptr, wr_ptr, prd_addr, prdata, wres;
	periph_write_type pwr;
	logic [7:0] mem [RAMB];
	logic [15:0] preg [8] = '{default: 16'h0000};
	logic [15:0] map [7] = '{16'h1040, 16'h1ffe, 16'h8000, 16'hfffe, 16'h0100, 16'h0ffe, 16'h7ffe};
	logic [15:0] back [5] = '{16'h0004, 16'h0008, 16'h1002, 16'h1004, 16'h1003};
	note_type q[$];
	note_type cur;
	int err_total = 0;
	int compares = 0;
	int cyc = 0;
	int seed;

	// ==========================================================
	// design and partner
	data_space_access_decode #(.RAM_BYTES(RAMB)) u_dut (
		.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
		.rd_req_in(rd_req), .rd_data_out(rd_data), .rd_done_out(rd_done), .rd_ptr_next_out(rd_ptr),
		.wr_req_in(wr_req), .wr_data_in(wr_data), .wr_done_out(wr_done), .wr_ptr_next_out(wr_ptr),
		.addr_err_out(aerr), .addr_err_write_out(aerr_w),
		.periph_rd_en_out(prd_en), .periph_rd_addr_out(prd_addr), .periph_rdata_in(prdata),
		.periph_hit_in(phit), .periph_wr_out(pwr),
		.wreg_op_in(wop), .wreg_old_in(wold), .wreg_load_in(wload), .wreg_result_out(wres)
	);

	periph_reg_model u_regs (
		.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .rd_addr_in(prd_addr),
		.rdata_out(prdata), .hit_out(phit), .wr_in(pwr)
	);

	initial begin
		sys_clk_in = 1'b0;
		forever #20 sys_clk_in = ~sys_clk_in;
	end

	// ==========================================================
	// expectations
	function automatic logic [15:0] rnd();
		return $random(seed);
	endfunction

	function automatic access_req_type mk(logic v, logic b, addr_mode_type m, logic [15:0] a, logic pi);
		access_req_type r;
		// unused fields carry noise so a wrong mode mux shows up
		r = {$random(seed), $random(seed)};
		r.valid = v;
		r.is_byte = b;
		r.mode = m;
		r.post_inc = pi;
		if (m == MODE_NEAR) r.near_field = a[12:0];
		else if (m == MODE_DIRECT) r.direct_addr = a;
		else r.pointer = a;
		return r;
	endfunction

	function automatic logic [15:0] ea_of(access_req_type r);
		if (r.mode == MODE_NEAR) return {3'h0, r.near_field};
		if (r.mode == MODE_DIRECT) return r.direct_addr;
		return r.pointer;
	endfunction

	function automatic logic [15:0] pnext(access_req_type r);
		if (r.mode == MODE_INDIRECT && r.post_inc) return r.pointer + (r.is_byte ? STEP_BYTE : STEP_WORD);
		return r.pointer;
	endfunction

	function automatic logic [15:0] word_at(logic [15:0] a);
		int k;
		k = int'({a[15:1], 1'b0}) - int'(RAM_BASE);
		if (a < 16'h0010) return preg[a[3:1]];
		if (k >= 0 && k < RAMB) return {mem[k + 1], mem[k]};
		return 16'h0000;
	endfunction

	function automatic logic [15:0] wexp(wreg_op_type op, logic [15:0] o, logic [15:0] l);
		case (op)
			WOP_WORD: return l;
			WOP_BYTE: return {o[15:8], l[7:0]};
			WOP_SIGN: return {{8{o[7]}}, o[7:0]};
			WOP_WIDEN: return {8'h00, o[7:0]};
			default: return o;
		endcase
	endfunction

	// ==========================================================
	// one cycle of stimulus, with its note for the monitor
	task automatic step(access_req_type r, access_req_type w, logic [15:0] d, wreg_op_type op);
		note_type n;
		logic [15:0] ra, wa, rw, o, l;
		int k;
		o = rnd();
		l = rnd();
		ra = ea_of(r);
		wa = ea_of(w);
		rw = word_at(ra);
		@(posedge sys_clk_in);
		rd_req <= r;
		wr_req <= w;
		wr_data <= d;
		wop <= op;
		wold <= o;
		wload <= l;
		n.stamp = cyc;
		n.rv = r.valid;
		n.rdat = r.is_byte ? {8'h00, ra[0] ? rw[15:8] : rw[7:0]} : rw;
		n.rptr = pnext(r);
		n.wv = w.valid;
		n.wptr = pnext(w);
		n.errw = w.valid && !w.is_byte && wa[0];
		n.err = n.errw || (r.valid && !r.is_byte && ra[0]);
		n.wres = wexp(op, o, l);
		q.push_back(n);
		// a misaligned word write leaves memory and control registers untouched; its pointer still steps
		if (w.valid && !n.errw) begin
			k = int'(wa) - int'(RAM_BASE);
			if (k >= 0 && k < RAMB) begin
				if (!w.is_byte || !wa[0]) mem[k & ~1] = d[7:0];
				if (!w.is_byte || wa[0]) mem[k | 1] = w.is_byte ? d[7:0] : d[15:8];
			end else if (wa < 16'h0010) begin
				if (!w.is_byte || !wa[0]) preg[wa[3:1]][7:0] = d[7:0];
				if (!w.is_byte || wa[0]) preg[wa[3:1]][15:8] = w.is_byte ? d[7:0] : d[15:8];
			end
		end
	endtask

	// ==========================================================
	// monitor: oldest note against the outputs, at the falling edge one cycle after it was driven
	always @(negedge sys_clk_in) begin
		if (q.size() > 0 && q[0].stamp + 2 <= cyc) begin
			cur = q.pop_front();
			`CHK(rd_done, cur.rv)
			if (cur.rv) `CHK(rd_data, cur.rdat)
			if (cur.rv) `CHK(rd_ptr, cur.rptr)
			`CHK(wr_done, cur.wv)
			if (cur.wv) `CHK(wr_ptr, cur.wptr)
			`CHK(aerr, cur.err)
			`CHK(aerr_w, cur.errw)
			`CHK(wres, cur.wres)
		end
	end

	// control read port is combinational: checked in the cycle the request stands
	always @(negedge sys_clk_in) begin
		if (nrst_in) begin
			`CHK(prd_en, rd_req.valid && ea_of(rd_req) <= 16'h0fff)
			`CHK(prd_addr, ea_of(rd_req) & 16'hfffe)
		end
	end

	// a hang counts as a mismatch
	always @(posedge sys_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			err_total++;
			results();
		end
	end

	task automatic results();
		$display("mismatches %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ==========================================================
	// scenarios
	initial begin
		seed = 32'h7a1cd16e;
		idle = '0;
		nrst_in = 1'b0;
		rd_req = '0;
		wr_req = '0;
		wr_data = 16'h0000;
		wop = WOP_NONE;
		wold = 16'h0000;
		wload = 16'h0000;
		repeat (3) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		for (int i = 0; i < 20; i++) step(idle, idle, 16'h0000, wreg_op_type'(i % 5));
		for (int i = 0; i < RAMB; i += 2) step(idle, mk(1, 0, MODE_INDIRECT, RAM_BASE + 16'(i), 1), rnd(), WOP_NONE);
		// byte write racing a read of its own word, which sees the old word
		for (int i = 0; i < 16; i++) step(mk(1, 0, MODE_DIRECT, RAM_BASE + 16'(i & ~1), 0), mk(1, 1, MODE_DIRECT, RAM_BASE + 16'(i), 0), rnd(), WOP_NONE);
		for (int i = 0; i < RAMB; i++) step(mk(1, 1, MODE_INDIRECT, RAM_BASE + 16'(i), 1), idle, 16'h0000, WOP_NONE);
		foreach (map[j]) begin
			step(mk(1, 0, MODE_DIRECT, map[j], 0), mk(1, 0, MODE_INDIRECT, map[j], 1), rnd(), WOP_NONE);
			step(mk(1, 1, MODE_INDIRECT, map[j] + 16'h0001, 0), idle, 16'h0000, WOP_NONE);
		end
		step(mk(1, 0, MODE_NEAR, RAM_BASE + 16'h0004, 0), mk(1, 0, MODE_NEAR, 16'h0004, 0), rnd(), WOP_NONE);
		step(idle, mk(1, 1, MODE_DIRECT, 16'h0009, 0), rnd(), WOP_NONE);
		step(idle, mk(1, 0, MODE_INDIRECT, 16'h0005, 1), rnd(), WOP_NONE);
		step(mk(1, 0, MODE_DIRECT, RAM_BASE + 16'h0005, 0), mk(1, 0, MODE_DIRECT, RAM_BASE + 16'h0003, 0), rnd(), WOP_NONE);
		repeat (2) step(idle, idle, 16'h0000, WOP_NONE);
		foreach (back[j]) step(mk(1, 0, MODE_NEAR, back[j], 0), idle, 16'h0000, WOP_SIGN);
		repeat (3) step(idle, idle, 16'h0000, WOP_NONE);
		repeat (3) @(negedge sys_clk_in);
		results();
	end
endmodule

`default_nettype wire
